// ### src/dfd_pkg.sv
// Package: register map, field positions and reset values for the driver fault logic
package dfd_pkg;
  // Register byte addresses
  localparam logic [7:0] DFD_CONFIG_ADDR  = 8'h00;
  localparam logic [7:0] DFD_STATUS_ADDR  = 8'h04;
  localparam logic [7:0] DFD_STEPCNT_ADDR = 8'h08;
  localparam logic [7:0] DFD_IRQST_ADDR   = 8'h0C;
  localparam logic [7:0] DFD_IRQMSK_ADDR  = 8'h10;
  // Global config fields
  localparam int DFD_EN_BIT      = 0;
  localparam int DFD_IDXSTEP_BIT = 1;
  localparam int DFD_STALLEN_BIT = 2;
  localparam int DFD_OTSEL_LSB   = 3;
  localparam int DFD_PWSEL_BIT   = 5;
  localparam logic [5:0] DFD_CONFIG_RST = 6'h00;
  // Status fields
  localparam int DFD_OVT_BIT  = 0;
  localparam int DFD_OTPW_BIT = 1;
  localparam int DFD_GNDA_BIT = 2;
  localparam int DFD_GNDB_BIT = 3;
  localparam int DFD_SUPA_BIT = 4;
  localparam int DFD_SUPB_BIT = 5;
  localparam int DFD_OLA_BIT  = 6;
  localparam int DFD_OLB_BIT  = 7;
  localparam int DFD_NFLAG    = 8;
  // Temperature sensor levels (thermometer code bits)
  localparam int DFD_T120 = 0;
  localparam int DFD_T143 = 1;
  localparam int DFD_T150 = 2;
  localparam int DFD_T157 = 3;
  // Threshold selection codes
  localparam logic [1:0] DFD_OTSEL_143 = 2'h0;
  localparam logic [1:0] DFD_OTSEL_150 = 2'h1;
  localparam logic [1:0] DFD_OTSEL_157 = 2'h2;
  // Short retries before shutdown
  localparam logic [1:0] DFD_SHORT_RETRIES = 2'h3;
  localparam int DFD_STEPCNT_W = 10;
endpackage

// ### src/dfd_short_guard.sv
// Per-bridge short detection with retry filter and latched shutdown
`timescale 1ns/100ps
`default_nettype none
module dfd_short_guard
  import dfd_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control
  input  wire logic drv_enable,
  // Detector pulses, one per chopper attempt
  input  wire logic gnd_event,
  input  wire logic sup_event,
  // Result
  output logic      gnd_flag,
  output logic      sup_flag
);
  logic [1:0] gnd_cnt_q;
  logic [1:0] sup_cnt_q;
  logic       clr_seen_q;

  // Driver disable clears the retry history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gnd_cnt_q <= 2'h0;
      sup_cnt_q <= 2'h0;
    end
    else if (!drv_enable)
    begin
      gnd_cnt_q <= 2'h0;
      sup_cnt_q <= 2'h0;
    end
    else
    begin
      if (gnd_event && gnd_cnt_q != DFD_SHORT_RETRIES)
        gnd_cnt_q <= gnd_cnt_q + 2'h1;
      if (sup_event && sup_cnt_q != DFD_SHORT_RETRIES)
        sup_cnt_q <= sup_cnt_q + 2'h1;
    end
  end

  // Fourth event after three retries confirms the short
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gnd_flag <= 1'b0;
      sup_flag <= 1'b0;
    end
    else if (!drv_enable)
    begin
      gnd_flag <= 1'b0;
      sup_flag <= 1'b0;
    end
    else
    begin
      if (gnd_event && gnd_cnt_q == DFD_SHORT_RETRIES)
        gnd_flag <= 1'b1;
      if (sup_event && sup_cnt_q == DFD_SHORT_RETRIES)
        sup_flag <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clr_seen_q <= 1'b0;
    else
      clr_seen_q <= !drv_enable;
  end

  a_retry_filter : assert property (@(posedge pclk) disable iff (!presetn)
    $rose(gnd_flag) |-> $past(gnd_cnt_q) == 2'h3)
    else $error("short flag set before three retries");
  a_short_hold : assert property (@(posedge pclk) disable iff (!presetn)
    gnd_flag && drv_enable |=> gnd_flag)
    else $error("short flag dropped without driver disable");
  a_short_clear : assert property (@(posedge pclk) disable iff (!presetn)
    clr_seen_q |-> !gnd_flag && !sup_flag)
    else $error("short flag survived driver disable");
endmodule
`default_nettype wire

// ### src/dfd_top.sv
// Driver fault diagnostics: temperature, shorts, open load, fault and index pins, APB registers
// Operation
// - Default shutdown at 143 degree level, pre-warning at 120 degree level.
// - Optional 150 degree shutdown, pre-warning selectable as 120 or 143.
// - Optional 157 degree shutdown with 143 degree pre-warning, register only.
// - After overtemperature, drivers stay off until below the pre-warning level.
// - Short confirmed only after three retries, filtering spurious events.
// - Confirmed short turns off only its bridge and sets its flag.
// - Short shutdown holds until host disables then re-enables the driver.
// - Open-load flag per coil when target current is not reached.
// - Open-load flags are informative only, no driver action.
// - Fault pin high when driver cannot run or stall detected while stall detection is enabled.
// - Index pin high at microstep counter zero by default.
// - Index step option toggles the pin on every executed step.
// - Microstep counter wraps 1023 to 0 counting up.
`timescale 1ns/100ps
`default_nettype none
module dfd_top
  import dfd_pkg::*;
#(
  parameter int STEPCNT_W = dfd_pkg::DFD_STEPCNT_W
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // OTP strap choosing 150 degree shutdown
  input  wire logic        otp_ot150,
  // Temperature comparators, bit per level 120/143/150/157
  input  wire logic [3:0]  temp_above,
  // Short detector pulses, bridge A and B
  input  wire logic        short_gnd_a,
  input  wire logic        short_gnd_b,
  input  wire logic        short_sup_a,
  input  wire logic        short_sup_b,
  // Current regulation reach per coil
  input  wire logic        coil_a_low,
  input  wire logic        coil_b_low,
  // Sequencer
  input  wire logic        step_pulse,
  input  wire logic        step_dir,
  input  wire logic [8:0]  step_width,
  input  wire logic        stall_detect,
  input  wire logic        undervoltage,
  // Bridge enables and pins
  output logic             bridge_a_en,
  output logic             bridge_b_en,
  output logic             fault_output_pin,
  output logic             index_pin,
  output logic             irq
);
  logic [5:0]         global_config_register;
  logic [STEPCNT_W-1:0] microstep_counter;
  logic               overtemp_shutdown_flag;
  logic               otpw_q;
  logic               ola_q;
  logic               olb_q;
  logic               short_ground_bridge_a_flag;
  logic               short_ground_bridge_b_flag;
  logic               short_supply_bridge_a_flag;
  logic               short_supply_bridge_b_flag;
  logic [DFD_NFLAG-1:0] irq_st_q;
  logic [DFD_NFLAG-1:0] irq_msk_q;
  logic [DFD_NFLAG-1:0] status_d;
  logic [DFD_NFLAG-1:0] status_q;
  logic               drv_en;
  logic               otp_cap_q;
  logic               otp_ot150_q;
  logic [1:0]         otsel;
  logic               ot_trip;
  logic               pw_level;
  logic               apb_wr;
  logic               apb_rd;
  logic               step_exec;

  assign drv_en    = global_config_register[DFD_EN_BIT];
  assign apb_wr    = psel && penable && pwrite;
  assign apb_rd    = psel && !penable && !pwrite;
  assign step_exec = step_pulse && drv_en && bridge_a_en && bridge_b_en;

  // Strap caught once after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      otp_cap_q   <= 1'b0;
      otp_ot150_q <= 1'b0;
    end
    else if (!otp_cap_q)
    begin
      otp_cap_q   <= 1'b1;
      otp_ot150_q <= otp_ot150;
    end
  end

  // Register selection overrides the strap only when nonzero
  function automatic logic [1:0] dfd_eff_otsel(input logic [1:0] reg_sel, input logic strap);
    if (reg_sel != DFD_OTSEL_143)
      return reg_sel;
    return strap ? DFD_OTSEL_150 : DFD_OTSEL_143;
  endfunction

  assign otsel = dfd_eff_otsel(global_config_register[DFD_OTSEL_LSB +: 2], otp_ot150_q);

  // Shutdown and pre-warning levels per selected setting
  always_comb
  begin
    unique case (otsel)
      DFD_OTSEL_150:
      begin
        ot_trip  = temp_above[DFD_T150];
        pw_level = global_config_register[DFD_PWSEL_BIT] ? temp_above[DFD_T143] : temp_above[DFD_T120];
      end
      DFD_OTSEL_157:
      begin
        ot_trip  = temp_above[DFD_T157];
        pw_level = temp_above[DFD_T143];
      end
      default:
      begin
        ot_trip  = temp_above[DFD_T143];
        pw_level = temp_above[DFD_T120];
      end
    endcase
  end

  // Shutdown latch releases only below the pre-warning level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overtemp_shutdown_flag <= 1'b0;
      otpw_q                 <= 1'b0;
    end
    else
    begin
      otpw_q <= pw_level;
      if (ot_trip)
        overtemp_shutdown_flag <= 1'b1;
      else if (!pw_level)
        overtemp_shutdown_flag <= 1'b0;
    end
  end

  dfd_short_guard u_guard_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .drv_enable (drv_en),
    .gnd_event  (short_gnd_a),
    .sup_event  (short_sup_a),
    .gnd_flag   (short_ground_bridge_a_flag),
    .sup_flag   (short_supply_bridge_a_flag)
  );

  dfd_short_guard u_guard_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .drv_enable (drv_en),
    .gnd_event  (short_gnd_b),
    .sup_event  (short_sup_b),
    .gnd_flag   (short_ground_bridge_b_flag),
    .sup_flag   (short_supply_bridge_b_flag)
  );

  // Open load only reports; nothing else reads these flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ola_q <= 1'b0;
      olb_q <= 1'b0;
    end
    else
    begin
      ola_q <= coil_a_low && drv_en;
      olb_q <= coil_b_low && drv_en;
    end
  end

  // Each bridge gated by its own shorts only; open load is excluded
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bridge_a_en <= 1'b0;
      bridge_b_en <= 1'b0;
    end
    else
    begin
      bridge_a_en <= drv_en && !ot_trip && !overtemp_shutdown_flag
                     && !short_ground_bridge_a_flag && !short_supply_bridge_a_flag;
      bridge_b_en <= drv_en && !ot_trip && !overtemp_shutdown_flag
                     && !short_ground_bridge_b_flag && !short_supply_bridge_b_flag;
    end
  end

  // Fault pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_output_pin <= 1'b0;
    else
      fault_output_pin <= overtemp_shutdown_flag || undervoltage
                          || short_ground_bridge_a_flag || short_ground_bridge_b_flag
                          || short_supply_bridge_a_flag || short_supply_bridge_b_flag
                          || (global_config_register[DFD_STALLEN_BIT] && stall_detect);
  end

  // Microstep counter, natural wrap at the counter width
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      microstep_counter <= '0;
    else if (step_exec)
    begin
      if (!step_dir)
        microstep_counter <= microstep_counter + STEPCNT_W'(step_width);
      else
        microstep_counter <= microstep_counter - STEPCNT_W'(step_width);
    end
  end

  // Index pin: zero position or step toggle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      index_pin <= 1'b0;
    else if (global_config_register[DFD_IDXSTEP_BIT])
    begin
      if (step_exec)
        index_pin <= !index_pin;
    end
    else
      index_pin <= (microstep_counter == '0);
  end

  assign status_d = {olb_q, ola_q, short_supply_bridge_b_flag, short_supply_bridge_a_flag,
                     short_ground_bridge_b_flag, short_ground_bridge_a_flag, otpw_q, overtemp_shutdown_flag};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_q <= '0;
    else
      status_q <= status_d;
  end

  // Sticky events on rising flags; set beats write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_st_q <= '0;
    else
      irq_st_q <= (irq_st_q & ~((apb_wr && paddr == DFD_IRQST_ADDR) ? pwdata[DFD_NFLAG-1:0] : '0))
                  | (status_d & ~status_q);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_st_q & irq_msk_q);
  end

  // Config and mask writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      global_config_register <= DFD_CONFIG_RST;
      irq_msk_q              <= '0;
    end
    else if (apb_wr)
    begin
      if (paddr == DFD_CONFIG_ADDR)
        global_config_register <= pwdata[5:0];
      if (paddr == DFD_IRQMSK_ADDR)
        irq_msk_q <= pwdata[DFD_NFLAG-1:0];
    end
  end

  // Read data registered in setup; pready high in every access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {DFD_CONFIG_ADDR, DFD_STATUS_ADDR, DFD_STEPCNT_ADDR,
                                                     DFD_IRQST_ADDR, DFD_IRQMSK_ADDR});
      if (apb_rd)
      begin
        unique case (paddr)
          DFD_CONFIG_ADDR:  prdata <= {26'h0, global_config_register};
          DFD_STATUS_ADDR:  prdata <= {24'h0, status_q};
          DFD_STEPCNT_ADDR: prdata <= {{(32-STEPCNT_W){1'b0}}, microstep_counter};
          DFD_IRQST_ADDR:   prdata <= {24'h0, irq_st_q};
          DFD_IRQMSK_ADDR:  prdata <= {24'h0, irq_msk_q};
          default:          prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_ovt_release : assert property (@(posedge pclk) disable iff (!presetn)
    $fell(overtemp_shutdown_flag) |-> !$past(pw_level) && !$past(ot_trip))
    else $error("shutdown released above pre-warning");
  a_ovt_bridge_off : assert property (@(posedge pclk) disable iff (!presetn)
    overtemp_shutdown_flag |=> !bridge_a_en && !bridge_b_en)
    else $error("bridge on during overtemperature");
  a_ovt_default : assert property (@(posedge pclk) disable iff (!presetn)
    otsel == DFD_OTSEL_143 && temp_above[DFD_T143] |=> overtemp_shutdown_flag)
    else $error("default shutdown missed");
  a_ovt_157 : assert property (@(posedge pclk) disable iff (!presetn)
    otsel == DFD_OTSEL_157 && !temp_above[DFD_T157] && !overtemp_shutdown_flag |=> !overtemp_shutdown_flag)
    else $error("157 setting tripped early");
  a_short_a_only : assert property (@(posedge pclk) disable iff (!presetn)
    short_ground_bridge_a_flag && !short_ground_bridge_b_flag && !short_supply_bridge_b_flag
    && drv_en && !ot_trip && !overtemp_shutdown_flag |=> !bridge_a_en && bridge_b_en)
    else $error("short bridge gating wrong");
  a_ol_no_action : assert property (@(posedge pclk) disable iff (!presetn)
    drv_en && !ot_trip && !overtemp_shutdown_flag && !short_ground_bridge_a_flag && !short_supply_bridge_a_flag
    |=> bridge_a_en)
    else $error("bridge off without cause");
  a_fault_stall : assert property (@(posedge pclk) disable iff (!presetn)
    global_config_register[DFD_STALLEN_BIT] && stall_detect |=> fault_output_pin)
    else $error("stall not on fault pin");
  a_index_zero : assert property (@(posedge pclk) disable iff (!presetn)
    !global_config_register[DFD_IDXSTEP_BIT] && microstep_counter == '0 |=> index_pin)
    else $error("index missing at zero");
  a_index_toggle : assert property (@(posedge pclk) disable iff (!presetn)
    global_config_register[DFD_IDXSTEP_BIT] && step_exec |=> index_pin != $past(index_pin))
    else $error("index did not toggle");
  a_microstep_counter_wrap : assert property (@(posedge pclk) disable iff (!presetn)
    step_exec && !step_dir && step_width == 9'h001 && microstep_counter == 10'h3FF
    |=> microstep_counter == 10'h000)
    else $error("counter wrap wrong");
  a_ol_flag : assert property (@(posedge pclk) disable iff (!presetn)
    coil_a_low && drv_en |=> ola_q)
    else $error("open load flag missed");

  c_ovt_trip : cover property (@(posedge pclk) disable iff (!presetn) $rose(overtemp_shutdown_flag));
  c_short_a : cover property (@(posedge pclk) disable iff (!presetn) $rose(short_ground_bridge_a_flag));
  c_index_tog : cover property (@(posedge pclk) disable iff (!presetn)
    global_config_register[DFD_IDXSTEP_BIT] && step_exec);
  c_irq : cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule
`default_nettype wire

// ### verif/dfd_host_mon.sv
// Host-side pin monitor counting index pin toggles
`timescale 1ns/100ps
`default_nettype none
module dfd_host_mon
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Watched pin
  input  wire logic index_pin,
  output int        idx_toggles
);
  logic idx_q;
  // Timer input of the host counts each edge of the index pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      idx_q       <= 1'b0;
      idx_toggles <= 0;
    end
    else
    begin
      idx_q <= index_pin;
      if (idx_q != index_pin)
        idx_toggles <= idx_toggles + 1;
    end
  end
endmodule
`default_nettype wire

// ### verif/dfd_tb.sv
// Testbench for the driver fault block over APB and its pins
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("unexpected t=%0t got=%0h exp=%0h", $time, g, e); end end
module driver_fault_diagnostics_tb_top;
  import dfd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  temp_above, shorts;
  logic        coil_a_low, coil_b_low, step_pulse, step_dir, stall_detect, undervoltage, otp_ot150;
  logic [8:0]  step_width;
  logic        bridge_a_en, bridge_b_en, fault_output_pin, index_pin, irq;
  int          n_fail, checks_done, idx_toggles, t0;
  logic [5:0]  cfg [4] = '{6'h01, 6'h09, 6'h29, 6'h11};
  int          pw [4] = '{0, 0, 1, 1};
  int          sd [4] = '{1, 2, 2, 3};

  always #10 pclk = ~pclk;

  dfd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .otp_ot150(otp_ot150), .temp_above(temp_above), .short_gnd_a(shorts[0]), .short_gnd_b(shorts[1]),
    .short_sup_a(shorts[2]), .short_sup_b(shorts[3]), .coil_a_low(coil_a_low), .coil_b_low(coil_b_low),
    .step_pulse(step_pulse), .step_dir(step_dir), .step_width(step_width), .stall_detect(stall_detect),
    .undervoltage(undervoltage), .bridge_a_en(bridge_a_en), .bridge_b_en(bridge_b_en),
    .fault_output_pin(fault_output_pin), .index_pin(index_pin), .irq(irq));

  dfd_host_mon host_u (.pclk(pclk), .presetn(presetn), .index_pin(index_pin), .idx_toggles(idx_toggles));

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No local timeout; only the watchdog ends a wait for a pready that never comes
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe = 1'b0);
    apb(1'b0, a, 32'h0);
    `CHK(rdat, exp)
    `CHK(err, xe)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(err, 1'b0)
  endtask

  task automatic pins(input logic [2:0] e);
    `CHK({bridge_a_en, bridge_b_en, fault_output_pin}, e)
  endtask

  task automatic set_temp(input int v);
    @(posedge pclk);
    temp_above <= 4'(v);
    tick(4);
  endtask

  task automatic pulse_short(input int i);
    @(posedge pclk);
    shorts[i] <= 1'b1;
    @(posedge pclk);
    shorts <= 4'h0;
    tick(2);
  endtask

  task automatic step(input int n);
    repeat (n)
    begin
      @(posedge pclk);
      step_pulse <= 1'b1;
      @(posedge pclk);
      step_pulse <= 1'b0;
    end
    tick(3);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {temp_above, shorts, coil_a_low, coil_b_low, step_pulse, step_dir, step_width} = '0;
    {stall_detect, undervoltage, otp_ot150, n_fail, checks_done} = '0;
    tick(5);
    presetn <= 1'b1;
    tick(1);
    rd(DFD_CONFIG_ADDR, 32'h0);
    rd(DFD_STATUS_ADDR, 32'h0);
    rd(DFD_STEPCNT_ADDR, 32'h0);
    rd(8'h14, 32'h0, 1'b1);
    `CHK(index_pin, 1'b1)
    $display("test reset done");
    wr(DFD_IRQMSK_ADDR, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(DFD_CONFIG_ADDR, {26'h0, cfg[i]});
      set_temp((1 << sd[i]) - 1);
      rd(DFD_STATUS_ADDR, 32'h2);
      pins(3'b110);
      set_temp((1 << (sd[i] + 1)) - 1);
      rd(DFD_STATUS_ADDR, 32'h3);
      pins(3'b001);
      set_temp((1 << (pw[i] + 1)) - 1);
      rd(DFD_STATUS_ADDR, 32'h3);
      set_temp((1 << pw[i]) - 1);
      rd(DFD_STATUS_ADDR, 32'h0);
      pins(3'b110);
    end
    // Cold sensor, so later status reads carry no pre-warning
    set_temp(0);
    rd(DFD_IRQST_ADDR, 32'h3);
    `CHK(irq, 1'b1)
    wr(DFD_IRQST_ADDR, 32'h1);
    tick(2);
    `CHK(irq, 1'b0)
    rd(DFD_IRQST_ADDR, 32'h2);
    $display("test temperature done");
    for (int i = 0; i < 4; i++)
    begin
      wr(DFD_CONFIG_ADDR, 32'h0);
      wr(DFD_CONFIG_ADDR, 32'h1);
      rd(DFD_STATUS_ADDR, 32'h0);
      repeat (3) pulse_short(i);
      rd(DFD_STATUS_ADDR, 32'h0);
      pins(3'b110);
      pulse_short(i);
      rd(DFD_STATUS_ADDR, 32'h1 << (2 + i));
      pins({i[0], !i[0], 1'b1});
      wr(DFD_CONFIG_ADDR, 32'h1);
      rd(DFD_STATUS_ADDR, 32'h1 << (2 + i));
    end
    wr(DFD_CONFIG_ADDR, 32'h0);
    wr(DFD_CONFIG_ADDR, 32'h1);
    // Bridge enables follow the enable bit one edge later
    tick(2);
    pins(3'b110);
    $display("test shorts done");
    coil_a_low <= 1'b1;
    tick(3);
    rd(DFD_STATUS_ADDR, 32'h40);
    coil_b_low <= 1'b1;
    tick(3);
    rd(DFD_STATUS_ADDR, 32'hC0);
    `CHK({bridge_a_en, bridge_b_en}, 2'b11)
    {coil_a_low, coil_b_low} <= 2'b00;
    wr(DFD_CONFIG_ADDR, 32'h5);
    stall_detect <= 1'b1;
    tick(3);
    `CHK(fault_output_pin, 1'b1)
    wr(DFD_CONFIG_ADDR, 32'h1);
    tick(2);
    `CHK(fault_output_pin, 1'b0)
    stall_detect <= 1'b0;
    undervoltage <= 1'b1;
    tick(3);
    `CHK(fault_output_pin, 1'b1)
    undervoltage <= 1'b0;
    $display("test open load and fault pin done");
    step_width <= 9'h100;
    step(1);
    rd(DFD_STEPCNT_ADDR, 32'h100);
    `CHK(index_pin, 1'b0)
    step(3);
    rd(DFD_STEPCNT_ADDR, 32'h0);
    `CHK(index_pin, 1'b1)
    step_dir <= 1'b1;
    step_width <= 9'h001;
    step(1);
    rd(DFD_STEPCNT_ADDR, 32'h3FF);
    // Single step up from the top value
    step_dir <= 1'b0;
    step(1);
    rd(DFD_STEPCNT_ADDR, 32'h0);
    wr(DFD_CONFIG_ADDR, 32'h3);
    tick(3);
    t0 = idx_toggles;
    step(3);
    `CHK(idx_toggles - t0, 3)
    $display("test steps done");
    // Second reset with the strap set; strap is only caught after release
    @(posedge pclk);
    presetn   <= 1'b0;
    otp_ot150 <= 1'b1;
    tick(5);
    presetn <= 1'b1;
    tick(1);
    rd(DFD_CONFIG_ADDR, 32'h0);
    `CHK(index_pin, 1'b1)
    wr(DFD_CONFIG_ADDR, 32'h1);
    set_temp(3);
    rd(DFD_STATUS_ADDR, 32'h2);
    pins(3'b110);
    set_temp(7);
    rd(DFD_STATUS_ADDR, 32'h3);
    pins(3'b001);
    set_temp(0);
    rd(DFD_STATUS_ADDR, 32'h0);
    $display("test strap done");
    give_verdict();
  end
endmodule
`default_nettype wire
